// >>> inc/sfpi_pkg.sv
// Constants and types shared by both ends of the serial flash pin link.
// Assumes a 20 MHz pclk on both ends.
package sfpi_pkg;
  localparam int CLK_MHZ       = 20;
  localparam int RESET_MIN_NS  = 1000;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
  // The device accepts a pulse half as long as the host guarantees.
  localparam int RESET_DET_CYC = RESET_MIN_CYC / 2;
  localparam int SCLK_HALF_CYC = 8;
  localparam int OP_CYCLES     = 64;

  localparam logic [14:0] ARRAY_SECTORS = 15'h4000;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TX   = 8'h04;
  localparam logic [7:0] OFS_RX   = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;

  localparam int CTRL_CS    = 0;
  localparam int CTRL_RST   = 1;
  localparam int CTRL_MODE  = 2;
  localparam int CTRL_READ  = 4;
  localparam int CTRL_CPOL  = 5;
  localparam int CTRL_WP    = 6;
  localparam int CTRL_PAUSE = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  localparam int STAT_BUSY = 0;
  localparam int STAT_RXV  = 1;

  typedef enum logic [1:0] {SFPI_SINGLE, SFPI_DUAL, SFPI_QUAD} sfpi_mode_t;

  function automatic logic [3:0] sfpi_width(input sfpi_mode_t m);
    unique case (m)
      SFPI_SINGLE: sfpi_width = 4'h1;
      SFPI_DUAL:   sfpi_width = 4'h2;
      SFPI_QUAD:   sfpi_width = 4'h4;
      default:     sfpi_width = 4'h1;
    endcase
  endfunction
endpackage

// >>> inc/sfpi_if.sv
// Pin bundle between flash host and flash device.
// Resolves each data lane from the two output enables; an undriven
// lane reads high, as the pull-ups on the board would make it.
interface sfpi_if;
  logic       sclk;
  logic       cs_n;
  logic       rst_pin_n;
  logic [3:0] host_out;
  logic [3:0] host_oe_n;
  logic [3:0] dev_out;
  logic [3:0] dev_oe_n;
  logic [3:0] lane;

  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign lane[i] = !host_oe_n[i] ? host_out[i] :
                     !dev_oe_n[i]  ? dev_out[i]  : 1'b1;
  end

  modport dev  (input sclk, cs_n, rst_pin_n, lane,
                output dev_out, dev_oe_n);
  modport host (output sclk, cs_n, rst_pin_n, host_out, host_oe_n,
                input lane);
endinterface

// >>> hw/sfpi_sync3.sv
// Three-stage synchroniser with agreement filter, one per bit.
// Assumes d is asynchronous to pclk.
module sfpi_sync3
  import sfpi_pkg::*;
#(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         pclk,    // Clock.
  input  wire logic         presetn, // Async reset, active low.
  input  wire logic         ce,      // Clock enable.
  input  wire logic [W-1:0] d,       // Raw pins.
  output logic      [W-1:0] lvl,     // Accepted level.
  output logic      [W-1:0] rise,    // Pulse on accepted rise.
  output logic      [W-1:0] fall     // Pulse on accepted fall.
);
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_reg, s2_reg, s3_reg;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_reg  <= INIT[i];
        s2_reg  <= INIT[i];
        s3_reg  <= INIT[i];
        lvl[i]  <= INIT[i];
        rise[i] <= 1'b0;
        fall[i] <= 1'b0;
      end else if (ce) begin
        s1_reg  <= d[i];
        s2_reg  <= s1_reg;
        s3_reg  <= s2_reg;
        rise[i] <= (s2_reg == s3_reg) && s3_reg && !lvl[i];
        fall[i] <= (s2_reg == s3_reg) && !s3_reg && lvl[i];
        if (s2_reg == s3_reg) begin
          lvl[i] <= s3_reg;
        end
      end
    end
  end
endmodule

// >>> hw/sfpi_dev.sv
// Pin front end of a serial flash device: select, lane shifting,
// pause, write-protect, protection window and hardware reset pin.
// Assumes the flash core sets lane_mode and drive_phase per phase and
// offers tx_byte before the falling edge that takes it.
//
// Contract
// - Chip select high floats all data lanes.
// - Deselect never aborts a running internal cycle.
// - No instruction before first chip select fall.
// - Chip select low selects and enables shifting.
// - Single lane: sample input on rising edge.
// - Single lane: drive output on falling edge.
// - Dual, quad: bidirectional lanes, host turns around.
// - Lanes 0-1 single/dual, lanes 0-3 quad.
// - Quad only with enable; lanes 2,3 become data.
// - Write-protect low plus guard blocks status writes.
// - Protection window spans one sector to array.
// - Pause while selected floats output, ignores clock.
// - Pause release resumes the transfer in place.
// - No pause function while quad enable set.
// - Reset pin low ends all operations.
// - Reset pin acts in any state.
// - Clock modes 0 and 3 supported.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
module sfpi_dev
  import sfpi_pkg::*;
(
  sfpi_if.dev              link,                 // Pins.
  input  wire logic        pclk,                 // Clock.
  input  wire logic        presetn,              // Async reset, low.
  input  wire logic        ce,                   // Clock enable.
  input  wire sfpi_mode_t  lane_mode,            // Lanes of this phase.
  input  wire logic        drive_phase,          // Device outputs now.
  input  wire logic [7:0]  tx_byte,              // Next byte to send.
  output logic             tx_take,              // tx_byte taken.
  output logic      [7:0]  rx_byte,              // Received byte.
  output logic             rx_valid,             // rx_byte new.
  output logic             selected,             // Armed and selected.
  output logic             paused,               // Pause in force.
  input  wire logic        quad_lane_enable,     // Quad enable bit.
  input  wire logic        status_write_guard,   // Guard bit.
  input  wire logic        protect_complement,   // Complement bit.
  input  wire logic [3:0]  block_protect,        // Block protect bits.
  output logic             status_write_blocked, // Status write locked.
  output logic             prot_valid,           // Window not empty.
  output logic      [13:0] prot_lo,              // First sector.
  output logic      [13:0] prot_hi,              // Last sector.
  input  wire logic        op_start,             // Start internal cycle.
  output logic             op_busy,              // Internal cycle runs.
  output logic             hw_reset              // Reset pin in force.
);
  ////////////////////////////////////////////////////////////////////
  logic [2:0] ctl_lvl, ctl_rise, ctl_fall;
  logic [3:0] lane_lvl;
  logic       sclk_rise, sclk_fall, cs_fall, cs_n_lvl, rst_lvl;

  sfpi_sync3 #(.W(3), .INIT(3'h6)) u_ctl (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       ({link.rst_pin_n, link.cs_n, link.sclk}),
    .lvl     (ctl_lvl),
    .rise    (ctl_rise),
    .fall    (ctl_fall)
  );

  sfpi_sync3 #(.W(4), .INIT(4'hF)) u_lane (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       (link.lane),
    .lvl     (lane_lvl),
    .rise    (),
    .fall    ()
  );

  // Edges only are used, so idle level low or high both work.
  assign sclk_rise = ctl_rise[0];
  assign sclk_fall = ctl_fall[0];
  assign cs_fall   = ctl_fall[1];
  assign cs_n_lvl  = ctl_lvl[1];
  assign rst_lvl   = ctl_lvl[2];

  ////////////////////////////////////////////////////////////////////
  // Hardware reset pin: filtered length, then a synchronous clear
  // that overrides chip select, sclk edges and op_start; protection inputs still act.
  logic [7:0] rst_cnt_reg;
  logic       hw_rst;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt_reg <= 8'h00;
    end else if (ce) begin
      if (rst_lvl) begin
        rst_cnt_reg <= 8'h00;
      end else if (rst_cnt_reg != 8'(RESET_DET_CYC)) begin
        rst_cnt_reg <= rst_cnt_reg + 8'h01;
      end
    end
  end

  assign hw_rst   = (rst_cnt_reg == 8'(RESET_DET_CYC));
  assign hw_reset = hw_rst;

  ////////////////////////////////////////////////////////////////////
  logic armed_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg <= 1'b0;
    end else if (ce) begin
      if (hw_rst) begin
        armed_reg <= 1'b0;
      end else if (cs_fall) begin
        armed_reg <= 1'b1;
      end
    end
  end

  logic       wp_n, hold_n, lane_ok, active;
  logic [3:0] w;

  assign wp_n     = quad_lane_enable ? 1'b1 : lane_lvl[2];
  assign hold_n   = quad_lane_enable ? 1'b1 : lane_lvl[3];
  assign selected = armed_reg && !cs_n_lvl && !hw_rst;
  assign paused   = selected && !hold_n;
  assign lane_ok  = (lane_mode != SFPI_QUAD) || quad_lane_enable;
  assign active   = selected && !paused && lane_ok;
  assign w        = sfpi_width(lane_mode);

  ////////////////////////////////////////////////////////////////////
  // Shift engine. A pause only masks edges; the counter and shift
  // registers keep their contents, so the transfer resumes in place.
  logic [3:0] cnt_reg;
  logic [7:0] rx_sh_reg, tx_sh_reg, rx_next, tx_cur;
  logic [3:0] dout_reg, dout_next, oe_n;

  always_comb begin
    tx_cur = (cnt_reg == 4'h0) ? tx_byte : tx_sh_reg;
    unique case (lane_mode)
      SFPI_SINGLE: begin
        rx_next   = {rx_sh_reg[6:0], lane_lvl[0]};
        dout_next = {2'h0, tx_cur[7], 1'b0};
        oe_n      = 4'hD;
      end
      SFPI_DUAL: begin
        rx_next   = {rx_sh_reg[5:0], lane_lvl[1:0]};
        dout_next = {2'h0, tx_cur[7:6]};
        oe_n      = 4'hC;
      end
      SFPI_QUAD: begin
        rx_next   = {rx_sh_reg[3:0], lane_lvl};
        dout_next = tx_cur[7:4];
        oe_n      = 4'h0;
      end
      default: begin
        rx_next   = rx_sh_reg;
        dout_next = 4'h0;
        oe_n      = 4'hF;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg   <= 4'h0;
      rx_sh_reg <= 8'h00;
      tx_sh_reg <= 8'h00;
      dout_reg  <= 4'h0;
      rx_byte   <= 8'h00;
      rx_valid  <= 1'b0;
      tx_take   <= 1'b0;
    end else if (ce) begin
      rx_valid <= 1'b0;
      tx_take  <= 1'b0;
      if (hw_rst) begin
        cnt_reg   <= 4'h0;
        rx_sh_reg <= 8'h00;
        tx_sh_reg <= 8'h00;
      end else if (cs_fall) begin
        cnt_reg <= 4'h0;
      end else if (sclk_rise && active && !drive_phase) begin
        rx_sh_reg <= rx_next;
        if (cnt_reg + w == 4'h8) begin
          cnt_reg  <= 4'h0;
          rx_byte  <= rx_next;
          rx_valid <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + w;
        end
      end else if (sclk_fall && active && drive_phase) begin
        dout_reg  <= dout_next;
        tx_sh_reg <= tx_cur << w;
        tx_take   <= (cnt_reg == 4'h0);
        cnt_reg   <= (cnt_reg + w == 4'h8) ? 4'h0 : cnt_reg + w;
      end
    end
  end

  assign link.dev_out  = dout_reg;
  // Output enables are low only while selected, unpaused and driving.
  assign link.dev_oe_n = (active && drive_phase) ? oe_n : 4'hF;

  ////////////////////////////////////////////////////////////////////
  // Internal cycle timer: chip select is not looked at here.
  logic [7:0] op_cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_cnt_reg <= 8'h00;
    end else if (ce) begin
      if (hw_rst) begin
        op_cnt_reg <= 8'h00;
      end else if (op_start && op_cnt_reg == 8'h00) begin
        op_cnt_reg <= 8'(OP_CYCLES);
      end else if (op_cnt_reg != 8'h00) begin
        op_cnt_reg <= op_cnt_reg - 8'h01;
      end
    end
  end

  assign op_busy = (op_cnt_reg != 8'h00);

  ////////////////////////////////////////////////////////////////////
  // Protection window, top aligned; the complement protects the rest.
  logic [14:0] size, lo_top;

  always_comb begin
    if (block_protect == 4'h0) begin
      size = 15'h0000;
    end else if (block_protect == 4'hF) begin
      size = ARRAY_SECTORS;
    end else begin
      size = 15'h0001 << (block_protect - 4'h1);
    end
    lo_top = ARRAY_SECTORS - size;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_write_blocked <= 1'b0;
      prot_valid           <= 1'b0;
      prot_lo              <= 14'h0000;
      prot_hi              <= 14'h0000;
    end else if (ce) begin
      status_write_blocked <= status_write_guard && !wp_n;
      if (!protect_complement) begin
        prot_valid <= (size != 15'h0000);
        prot_lo    <= lo_top[13:0];
        prot_hi    <= 14'h3FFF;
      end else begin
        prot_valid <= (size != ARRAY_SECTORS);
        prot_lo    <= 14'h0000;
        prot_hi    <= 14'(lo_top - 15'h0001);
      end
    end
  end
endmodule

// >>> hw/sfpi_host.sv
// Serial flash host controller with an APB register slave.
// Assumes software orders chip select, direction and mode per phase.
module sfpi_host
  import sfpi_pkg::*;
(
  sfpi_if.host             link,    // Pins.
  input  wire logic        pclk,    // Clock.
  input  wire logic        presetn, // Async reset, active low.
  input  wire logic        ce,      // Clock enable.
  input  wire logic        psel,    // APB select.
  input  wire logic        penable, // APB enable.
  input  wire logic        pwrite,  // APB write.
  input  wire logic [7:0]  paddr,   // APB byte address.
  input  wire logic [31:0] pwdata,  // APB write data.
  output logic      [31:0] prdata,  // APB read data.
  output logic             pready,  // APB ready.
  output logic             pslverr  // APB error.
);
  typedef enum {H_IDLE, H_LOW, H_HIGH} sfpi_hst_t;

  ////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_reg, rst_cnt_reg, tx_sh_reg, rx_sh_reg, rx_reg;
  logic [7:0] rx_next;
  logic [3:0] hc_reg, sc_reg, hout_reg, hout_next, w, lane_lvl;
  logic       rxv_reg, sclk_reg, wr_acc, rd_acc, tx_wr, rx_rd, done;
  logic       mapped, last, half_end, wr_dir;
  sfpi_mode_t mode;
  sfpi_hst_t  st_reg;

  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_TX) ||
                  (paddr == OFS_RX) || (paddr == OFS_STAT);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_acc  = psel && penable && pwrite && mapped;
  assign rd_acc  = psel && penable && !pwrite;
  assign tx_wr   = wr_acc && paddr == OFS_TX && st_reg == H_IDLE;
  assign rx_rd   = rd_acc && paddr == OFS_RX;
  assign mode    = sfpi_mode_t'(ctrl_reg[CTRL_MODE +: 2]);
  assign w       = sfpi_width(mode);
  assign wr_dir  = !ctrl_reg[CTRL_READ];

  sfpi_sync3 #(.W(4), .INIT(4'hF)) u_lane (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       (link.lane),
    .lvl     (lane_lvl),
    .rise    (),
    .fall    ()
  );

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= CTRL_RESET;
      rst_cnt_reg <= 8'h00;
      rxv_reg     <= 1'b0;
      prdata      <= 32'h0000_0000;
    end else if (ce) begin
      if (wr_acc && paddr == OFS_CTRL) begin
        ctrl_reg           <= pwdata[7:0];
        ctrl_reg[CTRL_RST] <= 1'b0;
      end
      // Hardware keeps the pin low for the full minimum time.
      if (wr_acc && paddr == OFS_CTRL && pwdata[CTRL_RST]) begin
        rst_cnt_reg <= 8'(RESET_MIN_CYC);
      end else if (rst_cnt_reg != 8'h00) begin
        rst_cnt_reg <= rst_cnt_reg - 8'h01;
      end
      rxv_reg <= done || (rxv_reg && !rx_rd);
      if (psel && !penable) begin
        unique case (paddr)
          OFS_CTRL: prdata <= {24'h0, ctrl_reg[7:2],
                               rst_cnt_reg != 8'h00, ctrl_reg[0]};
          OFS_RX:   prdata <= {24'h0, rx_reg};
          OFS_STAT: prdata <= {30'h0, rxv_reg, st_reg != H_IDLE};
          default:  prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    unique case (mode)
      SFPI_SINGLE: begin
        hout_next = {3'h0, tx_sh_reg[7]};
        rx_next   = {rx_sh_reg[6:0], lane_lvl[1]};
      end
      SFPI_DUAL: begin
        hout_next = {2'h0, tx_sh_reg[7:6]};
        rx_next   = {rx_sh_reg[5:0], lane_lvl[1:0]};
      end
      default: begin
        hout_next = tx_sh_reg[7:4];
        rx_next   = {rx_sh_reg[3:0], lane_lvl};
      end
    endcase
  end

  assign half_end = (hc_reg == 4'(SCLK_HALF_CYC - 1));
  assign last     = (sc_reg + w == 4'h8);
  assign done     = st_reg == H_HIGH && half_end && last;

  // Data changes one pclk after sclk falls and stays seven of the eight
  // half-period cycles before the rising edge, which covers the device's input filter delay.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg    <= H_IDLE;
      hc_reg    <= 4'h0;
      sc_reg    <= 4'h0;
      sclk_reg  <= 1'b0;
      tx_sh_reg <= 8'h00;
      rx_sh_reg <= 8'h00;
      rx_reg    <= 8'h00;
      hout_reg  <= 4'h0;
    end else if (ce) begin
      unique case (st_reg)
        H_IDLE: begin
          sclk_reg <= ctrl_reg[CTRL_CPOL];
          hc_reg   <= 4'h0;
          sc_reg   <= 4'h0;
          if (tx_wr) begin
            st_reg    <= H_LOW;
            sclk_reg  <= 1'b0;
            tx_sh_reg <= pwdata[7:0];
          end
        end
        H_LOW: begin
          if (hc_reg == 4'h0) begin
            hout_reg  <= hout_next;
            tx_sh_reg <= tx_sh_reg << w;
          end
          hc_reg <= hc_reg + 4'h1;
          if (half_end) begin
            st_reg   <= H_HIGH;
            hc_reg   <= 4'h0;
            sclk_reg <= 1'b1;
          end
        end
        H_HIGH: begin
          hc_reg <= hc_reg + 4'h1;
          if (half_end) begin
            rx_sh_reg <= rx_next;
            hc_reg    <= 4'h0;
            sc_reg    <= sc_reg + w;
            if (last) begin
              st_reg   <= H_IDLE;
              sclk_reg <= ctrl_reg[CTRL_CPOL];
              rx_reg   <= rx_next;
            end else begin
              st_reg   <= H_LOW;
              sclk_reg <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Chip select starts high from reset, so the first select is a fall.
  assign link.cs_n      = !ctrl_reg[CTRL_CS];
  assign link.sclk      = sclk_reg;
  assign link.rst_pin_n = (rst_cnt_reg == 8'h00);
  // Lanes 2 and 3 carry write-protect and pause unless quad is used.
  assign link.host_out  = (mode == SFPI_QUAD) ? hout_reg :
                          {!ctrl_reg[CTRL_PAUSE], !ctrl_reg[CTRL_WP],
                           hout_reg[1:0]};
  // Read direction releases the data lanes for the device, except lane 0 in single mode.
  assign link.host_oe_n[3:2] = (mode == SFPI_QUAD) ?
                               {2{!wr_dir}} : 2'h0;
  assign link.host_oe_n[1]   = !(wr_dir && mode != SFPI_SINGLE);
  assign link.host_oe_n[0]   = (mode == SFPI_SINGLE) ? 1'b0 : !wr_dir;
endmodule

// >>> tb/sfpi_link_properties.sv
// Assertions on the flash pin link, placed beside the link interface.
// Assumes pclk, presetn and the quad enable come from the bench.
module sfpi_link_properties
  import sfpi_pkg::*;
(
  input wire logic       pclk,             // Clock.
  input wire logic       presetn,          // Reset, low.
  input wire logic       quad_lane_enable, // Quad enable.
  input wire logic       sclk,             // Serial clock.
  input wire logic       cs_n,             // Select, low.
  input wire logic       rst_pin_n,        // Reset pin, low.
  input wire logic [3:0] host_out,         // Host data.
  input wire logic [3:0] host_oe_n,        // Host enables.
  input wire logic [3:0] dev_out,          // Device data.
  input wire logic [3:0] dev_oe_n,         // Device enables.
  input wire logic [3:0] lane              // Resolved lanes.
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // Saturates so that a pin held low for long cannot wrap to zero.
  logic [7:0] rst_low_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_low_reg <= 8'h00;
    end else if (rst_pin_n) begin
      rst_low_reg <= 8'h00;
    end else if (rst_low_reg != 8'hFF) begin
      rst_low_reg <= rst_low_reg + 8'h01;
    end
  end
  ////////////////////////////////////////
  cs_float_a: assert property (cs_n [*8] |-> dev_oe_n == 4'hF)
    else $error("device drives while deselected");
  rst_width_a: assert property ($rose(rst_pin_n) |->
    rst_low_reg >= RESET_MIN_CYC) else $error("reset pulse too short");
  rst_float_a: assert property ($fell(rst_pin_n) |->
    ##19 dev_oe_n == 4'hF) else $error("device drives in reset");
  out_on_fall_a: assert property (($changed(dev_out) &&
    dev_oe_n != 4'hF) |-> !sclk) else $error("output moved off fall");
  idle_clock_a: assert property (($fell(cs_n) || $rose(cs_n))
    |-> $stable(sclk)) else $error("clock moved at select edge");
  sclk_high_a: assert property (($rose(sclk) && !cs_n) |->
    sclk [*8]) else $error("clock high half wrong");
  data_hold_a: assert property ((!cs_n && sclk && !host_oe_n[0])
    |-> $stable(host_out[0])) else $error("host data moved in high");
  pause_float_a: assert property ((!cs_n && !quad_lane_enable
    && !lane[3]) [*8] |-> dev_oe_n == 4'hF) else $error("pause ignored");
  quad_lanes_a: assert property (!quad_lane_enable |->
    dev_oe_n[3:2] == 2'b11) else $error("upper lanes without enable");
endmodule

// >>> tb/test_serial_flash_pin_interface.sv
// Bench joining the flash host and device across one pin link.
// Assumes the package, link interface and both ends are compiled.
module test_serial_flash_pin_interface
  import sfpi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, err, rx_valid, paused, op_busy, hw_reset;
  logic        qe = 1'b0;
  logic        guard = 1'b0;
  logic        cmpl = 1'b0;
  logic [3:0]  bp = 4'h0;
  logic        op_start = 1'b0;
  logic        drive = 1'b0;
  logic [7:0]  tx_byte = 8'h00;
  logic [7:0]  rx_byte, rx_last;
  logic        blocked, prot_valid, dev_sel;
  logic [13:0] prot_lo, prot_hi;
  sfpi_mode_t  mode = SFPI_SINGLE;
  int          mismatches = 0;
  int          num_checks = 0;
  int          rx_cnt = 0;
  sfpi_if lnk ();
  sfpi_host i_sfpi_host (.link(lnk), .pclk, .presetn, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  sfpi_dev i_sfpi_dev (.link(lnk), .pclk, .presetn, .ce,
    .lane_mode(mode), .drive_phase(drive), .tx_byte, .tx_take(),
    .rx_byte, .rx_valid, .selected(dev_sel), .paused, .quad_lane_enable(qe),
    .status_write_guard(guard), .protect_complement(cmpl),
    .block_protect(bp), .status_write_blocked(blocked), .prot_valid,
    .prot_lo, .prot_hi, .op_start, .op_busy, .hw_reset);
  sfpi_link_properties link_chk (.pclk, .presetn, .quad_lane_enable(qe),
    .sclk(lnk.sclk), .cs_n(lnk.cs_n), .rst_pin_n(lnk.rst_pin_n),
    .host_out(lnk.host_out), .host_oe_n(lnk.host_oe_n),
    .dev_out(lnk.dev_out), .dev_oe_n(lnk.dev_oe_n), .lane(lnk.lane));
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    if (rx_valid === 1'b1) begin
      rx_cnt++;
      rx_last = rx_byte;
    end
  end
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_idle();
    apb(1'b0, OFS_STAT, 32'h0);
    while (q[STAT_BUSY] !== 1'b0) apb(1'b0, OFS_STAT, 32'h0);
  endtask
  // Raises select first so every byte starts a fresh frame.
  task automatic xfer(input logic [7:0] c, b, input logic qv);
    apb(1'b1, OFS_CTRL, {24'h0, c & 8'hFE});
    mode <= sfpi_mode_t'(c[CTRL_MODE +: 2]);
    drive <= c[CTRL_READ];
    tx_byte <= b;
    qe <= qv;
    repeat (10) @(posedge pclk);
    apb(1'b1, OFS_CTRL, {24'h0, c});
    apb(1'b1, OFS_TX, {24'h0, b});
    wait_idle();
    repeat (4) @(posedge pclk);
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", {24'h0, CTRL_RESET}, q);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, q);
  endtask
  task automatic t_writes();
    logic [7:0] ctl [5] = '{8'h01, 8'h05, 8'h21, 8'h09, 8'h09};
    logic [7:0] dat [5] = '{8'hA5, 8'h3C, 8'h81, 8'h5A, 8'hC3};
    int n;
    for (int i = 0; i < 5; i++) begin
      n = rx_cnt;
      xfer(ctl[i], dat[i], i == 4);
      chk("rx count", (i == 3) ? n : n + 1, rx_cnt);
      if (i != 3) chk("rx byte", dat[i], rx_last);
    end
  endtask
  task automatic t_reads();
    logic [7:0] dat [3] = '{8'h96, 8'h4B, 8'hE1};
    for (int m = 0; m < 3; m++) begin
      xfer(8'h31 | 8'(m << 2), dat[m], m == 2);
      apb(1'b0, OFS_RX, 32'h0);
      chk("read byte", {24'h0, dat[m]}, q);
    end
  endtask
  task automatic t_pause();
    int n = rx_cnt;
    xfer(8'h81, 8'h11, 1'b0);
    chk("paused", 32'h1, paused);
    chk("paused rx", n, rx_cnt);
    // Pause lands after four bits; the next byte's first four complete it.
    apb(1'b1, OFS_CTRL, 32'h01);
    apb(1'b1, OFS_TX, 32'hA5);
    repeat (60) @(posedge pclk);
    apb(1'b1, OFS_CTRL, 32'h81);
    wait_idle();
    apb(1'b1, OFS_CTRL, 32'h01);
    apb(1'b1, OFS_TX, 32'h3C);
    wait_idle();
    repeat (4) @(posedge pclk);
    chk("resumed rx", 8'hA3, rx_last);
    chk("resumed count", n + 1, rx_cnt);
    xfer(8'h81, 8'h33, 1'b1);
    chk("quad pause", 8'h33, rx_last);
  endtask
  task automatic t_protect();
    logic [4:0]  sel [6] = '{5'h00, 5'h01, 5'h0F, 5'h11, 5'h1F, 5'h03};
    logic [31:0] e [6] = '{32'h0, 32'h1FFFFFFF, 32'h10003FFF,
                           32'h10003FFE, 32'h0, 32'h1FFF3FFF};
    qe <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      guard <= i[0];
      apb(1'b1, OFS_CTRL, i[1] ? 32'h40 : 32'h0);
      repeat (10) @(posedge pclk);
      chk("status lock", i == 3, blocked);
    end
    for (int i = 0; i < 6; i++) begin
      {cmpl, bp} <= sel[i];
      repeat (3) @(posedge pclk);
      chk("window", e[i],
          prot_valid ? {3'h0, 1'b1, prot_lo, prot_hi} : 32'h0);
    end
  endtask
  task automatic t_op_reset();
    int n;
    xfer(8'h01, 8'h77, 1'b0);
    op_start <= 1'b1;
    @(posedge pclk);
    op_start <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h0);
    repeat (30) @(posedge pclk);
    chk("busy deselected", 32'h1, op_busy);
    ce <= 1'b0;
    repeat (OP_CYCLES) @(posedge pclk);
    chk("busy frozen", 32'h1, op_busy);
    ce <= 1'b1;
    repeat (OP_CYCLES) @(posedge pclk);
    chk("busy ended", 32'h0, op_busy);
    apb(1'b1, OFS_CTRL, 32'h1);
    op_start <= 1'b1;
    @(posedge pclk);
    op_start <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h3);
    for (int k = 0; k < 25 && hw_reset !== 1'b1; k++) @(posedge pclk);
    @(negedge pclk);
    chk("pin reset", 32'h1, hw_reset);
    chk("op aborted", 32'h0, op_busy);
    repeat (40) @(posedge pclk);
    n = rx_cnt;
    apb(1'b1, OFS_TX, 32'h5C);
    wait_idle();
    repeat (4) @(posedge pclk);
    chk("unarmed rx", n, rx_cnt);
    chk("unarmed sel", 32'h0, dev_sel);
    xfer(8'h01, 8'h6D, 1'b0);
    chk("rearmed rx", 8'h6D, rx_last);
  endtask
  ////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Whole run is near 2100 cycles, so this only trips on a hang.
  initial begin
    repeat (30000) @(posedge pclk);
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_writes();
    t_reads();
    t_pause();
    t_protect();
    t_op_reset();
    end_of_test();
  end
endmodule
